// ==== rtl/adc_range_alarm_cfg.svh ====
// Purpose: Offsets, field positions and reset values of the range and alarm clear block.
// Assumes: Word-aligned AHB-Lite access, byte address is four times the register index.
// Notes: Definitions only.
`ifndef ADC_RANGE_ALARM_CFG_SVH
`define ADC_RANGE_ALARM_CFG_SVH

`define RNG_IDX_RANGE 8'h52
`define RNG_IDX_CLRSRC 8'h53
`define RNG_IDX_CLREN 8'h54
`define RNG_IDX_STATUS 8'h60
`define RNG_IDX_MASK 8'h61
`define RNG_IDX_CLROUT 8'h62

`define RNG_RST_RANGE 16'hFFFF
`define RNG_RST_CLRSRC 16'h0004
`define RNG_RST_CLREN 16'h0000
`define RNG_RST_STATUS 16'h0000
`define RNG_RST_MASK 16'h0000

`define RNG_BIT_CH0_GAIN 15
`define RNG_BIT_CH2_GAIN 13
`define RNG_BIT_SRC_TOP 14
`define RNG_BIT_SRC_ANALOG_LO 11
`define RNG_BIT_SRC_LOCAL_LO 9
`define RNG_BIT_SRC_REMOTE_LO 5
`define RNG_BIT_SRC_R1_FAULT 4
`define RNG_BIT_SRC_R2_FAULT 3
`define RNG_BIT_SRC_OVERTEMP 2
`define RNG_BIT_EN_LO 3
`define RNG_BIT_EN_HI 14

// Writable bits of the clear-source and enable registers; the rest read zero.
`define RNG_MASK_CLRSRC 16'h7FFC
`define RNG_MASK_CLREN 16'h7FF8

`endif

// ==== rtl/adc_range_alarm_pkg.sv ====
// Purpose: Types shared by the range and alarm clear block.
// Assumes: Nothing beyond the constants header.
// Notes: Alarm sources are ordered to match clear-source bits 14 down to 2.
package adc_range_alarm_pkg;

	typedef logic [15:0] reg16_t;
	typedef logic [11:0] dac_vec_t;

	// One bit per alarm source, in the bit order of the clear-source register.
	typedef struct packed {
		logic analog0;
		logic analog1;
		logic analog2;
		logic analog3;
		logic localTempLow;
		logic localTempHigh;
		logic remote1Low;
		logic remote1High;
		logic remote2Low;
		logic remote2High;
		logic remote1Fault;
		logic remote2Fault;
		logic overtemp;
	} alarm_ev_t;

	// Data-phase context of an accepted AHB write.
	typedef struct packed {
		logic pending;
		logic [7:0] idx;
	} ahb_wr_t;

	// Range selections handed to the conversion engine.
	typedef struct packed {
		logic [15:0] chWide;
		logic pair01Wide;
		logic pair23Wide;
	} range_sel_t;

endpackage

// ==== rtl/adc_range_and_alarm_dac_clear.sv ====
// Purpose: Input range selection and alarm-driven DAC forced-clear logic.
// Assumes: Alarm events come from logic on core_clk; software is the only bus master.
// Notes: AHB-Lite slave, zero wait states, always OKAY.
// What this block does
// - Range register: bit 15-c sets channel c gain
// - Channel 0 gain also sets pair 0/1
// - Channel 2 gain also sets pair 2/3
// - Clear-source register, any mode, resets 0004h
// - Clear DAC when select, enable, status all set
// - Unselected source still flags, clears nothing
// - Analog alarm selects at bits 14..11
// - Local temperature low bit 10, high 9
// - Remote selects at bits 8..5
// - Bit 4 selects remote 1 fault
// - Bit 3 selects remote 2 fault
// - Bit 2 selects overtemp, resets to one
// - Overtemp ignores per-DAC enables, clears all
`timescale 1ns/1ps
`include "adc_range_alarm_cfg.svh"

module adc_range_and_alarm_dac_clear
	import adc_range_alarm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Alarm events from the monitor logic
	input wire alarm_ev_t alarmEvent,
	// Range selections and DAC forced clear
	output range_sel_t rangeSel,
	output dac_vec_t dacForceClear,
	// Interrupt
	output logic irq
);

	// ********************************************************************
	// Bus address phase
	// ********************************************************************

	logic addrValid;
	logic [7:0] addrIdx;
	ahb_wr_t wrCtx_r;
	logic rdAccept;

	// Only NONSEQ or SEQ transfers with word alignment reach the registers.
	assign addrValid = hsel && hready && htrans[1] && (haddr[1:0] == 2'h0)
		&& (haddr[31:10] == 22'h0);
	assign addrIdx = haddr[9:2];
	assign rdAccept = addrValid && !hwrite;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wrCtx_r <= '0;
		end else if (hready) begin
			wrCtx_r.pending <= addrValid && hwrite;
			wrCtx_r.idx <= addrIdx;
		end
	end

	// The slave never stretches a transfer and never reports an error.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ********************************************************************
	// Write strobes
	// ********************************************************************

	logic wrRange;
	logic wrClrSrc;
	logic wrClrEn;
	logic wrStatus;
	logic wrMask;
	reg16_t wData;

	assign wData = hwdata[15:0];
	assign wrRange = wrCtx_r.pending && (wrCtx_r.idx == `RNG_IDX_RANGE);
	assign wrClrSrc = wrCtx_r.pending && (wrCtx_r.idx == `RNG_IDX_CLRSRC);
	assign wrClrEn = wrCtx_r.pending && (wrCtx_r.idx == `RNG_IDX_CLREN);
	assign wrStatus = wrCtx_r.pending && (wrCtx_r.idx == `RNG_IDX_STATUS);
	assign wrMask = wrCtx_r.pending && (wrCtx_r.idx == `RNG_IDX_MASK);

	// ********************************************************************
	// Configuration registers
	// ********************************************************************

	reg16_t range_r;
	reg16_t range_nxt;
	reg16_t clrSrc_r;
	reg16_t clrSrc_nxt;
	reg16_t clrEn_r;
	reg16_t clrEn_nxt;
	reg16_t mask_r;
	reg16_t mask_nxt;

	// Next values are visible to a read in the same cycle, so a read that
	// directly follows a write returns the new value.
	always_comb begin
		range_nxt = wrRange ? wData : range_r;
		clrSrc_nxt = wrClrSrc ? (wData & `RNG_MASK_CLRSRC) : clrSrc_r;
		clrEn_nxt = wrClrEn ? (wData & `RNG_MASK_CLREN) : clrEn_r;
		mask_nxt = wrMask ? (wData & `RNG_MASK_CLRSRC) : mask_r;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			range_r <= `RNG_RST_RANGE;
		end else begin
			range_r <= range_nxt;
		end
	end

	// The selection acts whatever DAC mode is in use; no mode gates it.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clrSrc_r <= `RNG_RST_CLRSRC;
		end else begin
			clrSrc_r <= clrSrc_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clrEn_r <= `RNG_RST_CLREN;
		end else begin
			clrEn_r <= clrEn_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mask_r <= `RNG_RST_MASK;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// ********************************************************************
	// Range selection outputs
	// ********************************************************************

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rangeSel.chWide <= `RNG_RST_RANGE;
			rangeSel.pair01Wide <= 1'b1;
			rangeSel.pair23Wide <= 1'b1;
		end else begin
			for (int c = 0; c < 16; c++) begin
				rangeSel.chWide[c] <= range_nxt[15 - c];
			end
			rangeSel.pair01Wide <= range_nxt[`RNG_BIT_CH0_GAIN];
			rangeSel.pair23Wide <= range_nxt[`RNG_BIT_CH2_GAIN];
		end
	end

	// ********************************************************************
	// Alarm status flags
	// ********************************************************************

	reg16_t status_r;
	reg16_t status_nxt;
	reg16_t evVec;

	// Sources sit in bits 14 down to 2, in the same order as the selects.
	assign evVec = {1'b0, alarmEvent, 2'b00};

	// Flags are set on every alarm whatever the select says, so software
	// always sees the event; a set in the clearing cycle wins.
	always_comb begin
		status_nxt = status_r;
		if (wrStatus) begin
			status_nxt = status_r & ~wData;
		end
		status_nxt = (status_nxt | evVec) & `RNG_MASK_CLRSRC;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			status_r <= `RNG_RST_STATUS;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ********************************************************************
	// DAC forced clear
	// ********************************************************************

	logic [11:0] srcHit;
	logic anySrc;
	logic overtempHit;
	dac_vec_t clrEnBits;
	dac_vec_t clear_nxt;

	// Non-thermal sources qualify only when both select and flag are set.
	assign srcHit = clrSrc_r[`RNG_BIT_SRC_TOP:`RNG_BIT_SRC_OVERTEMP + 1]
		& status_r[`RNG_BIT_SRC_TOP:`RNG_BIT_SRC_OVERTEMP + 1];
	assign anySrc = |srcHit;
	assign overtempHit = clrSrc_r[`RNG_BIT_SRC_OVERTEMP]
		&& status_r[`RNG_BIT_SRC_OVERTEMP];
	assign clrEnBits = clrEn_r[`RNG_BIT_EN_HI:`RNG_BIT_EN_LO];

	// DAC n is gated by enable bit 3+n; the thermal path bypasses the
	// enables so a hot die parks every output while select bit 2 is set.
	assign clear_nxt = ({12{anySrc}} & clrEnBits)
		| {12{overtempHit}};

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dacForceClear <= '0;
		end else begin
			dacForceClear <= clear_nxt;
		end
	end

	// ********************************************************************
	// Interrupt
	// ********************************************************************

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_nxt & mask_nxt);
		end
	end

	// ********************************************************************
	// Read data
	// ********************************************************************

	reg16_t rdMux;

	always_comb begin
		unique case (addrIdx)
			`RNG_IDX_RANGE: rdMux = range_nxt;
			`RNG_IDX_CLRSRC: rdMux = clrSrc_nxt;
			`RNG_IDX_CLREN: rdMux = clrEn_nxt;
			`RNG_IDX_STATUS: rdMux = status_nxt;
			`RNG_IDX_MASK: rdMux = mask_nxt;
			`RNG_IDX_CLROUT: rdMux = {4'h0, dacForceClear};
			default: rdMux = 16'h0000;
		endcase
	end

	// Data is launched at the end of the address phase and held until the
	// next accepted read; unmapped indices return zero, while addresses above 3FFh are not accepted and leave the data held.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (rdAccept) begin
			hrdata <= {16'h0000, rdMux};
		end
	end

endmodule

// ==== verif/adc_range_alarm_sva.sv ====
// Purpose: Port assertions for the range and alarm clear block.
// Assumes: Reset is held for at least two clock edges.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
module adc_range_alarm_sva
	import adc_range_alarm_pkg::*;
(
	// Clock and bus
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// Alarm side
	input wire alarm_ev_t alarmEvent,
	input wire range_sel_t rangeSel,
	input wire dac_vec_t dacForceClear,
	input wire logic irq
);
	logic seen_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ****
	// Flags are sticky and only events set them, so no clear or interrupt may precede one.
	// ****
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			seen_r <= 1'b0;
		else if (|alarmEvent)
			seen_r <= 1'b1;
	end
	a_pair01_track: assert property (rangeSel.pair01Wide == rangeSel.chWide[0])
		else $error("pair 0/1 range differs from channel 0");
	a_pair23_track: assert property (rangeSel.pair23Wide == rangeSel.chWide[2])
		else $error("pair 2/3 range differs from channel 2");
	a_range_reset: assert property ($fell(sys_rst) |-> rangeSel == 18'h3FFFF)
		else $error("range not all wide after reset");
	a_clear_reset: assert property ($fell(sys_rst) |-> dacForceClear == 12'h000 && !irq)
		else $error("clear or interrupt active after reset");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_clear_cause: assert property (|dacForceClear |-> seen_r)
		else $error("clear without any alarm");
	a_irq_cause: assert property (irq |-> seen_r)
		else $error("interrupt without any alarm");
	a_range_written: assert property (!$stable(rangeSel) |->
		$past(hsel && hready && htrans[1] && hwrite && haddr == 32'h148, 2))
		else $error("range changed without a write");
	c_overtemp: cover property (alarmEvent.overtemp);
	c_clear_all: cover property (dacForceClear == 12'hFFF);
	c_irq: cover property (irq);
endmodule

bind adc_range_and_alarm_dac_clear adc_range_alarm_sva i_adc_range_alarm_sva (.core_clk,
	.sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
	.alarmEvent, .rangeSel, .dacForceClear, .irq);

// ==== verif/adc_range_and_alarm_dac_clear_bench.sv ====
// Purpose: Self-checking bench for the range and alarm clear block.
// Assumes: Zero-wait slave; outputs settle within three edges of a write.
// Notes: Register model kept in integers.
`timescale 1ns/1ps
module adc_range_and_alarm_dac_clear_bench;
	import adc_range_alarm_pkg::*;
	logic core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic hready, hreadyout, hresp, irq;
	alarm_ev_t alarmEvent = '0;
	range_sel_t rangeSel;
	dac_vec_t dacForceClear;
	int n_fail = 0, checked = 0, cyc = 0, expClr = 0;
	int rng = 32'hFFFF, src = 32'h4, en = 0, st = 0, msk = 0;
	assign hready = hreadyout;
	always #2 core_clk = ~core_clk;
	adc_range_and_alarm_dac_clear i_adc_range_and_alarm_dac_clear (.core_clk, .sys_rst, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp,
		.alarmEvent, .rangeSel, .dacForceClear, .irq);
	// ****
	// Bus cycles, model and comparisons.
	// ****
	task chk(string what, logic [31:0] e, logic [31:0] g);
		checked++;
		if (e !== g) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task bus(logic w, logic [31:0] a, logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task wr(logic [31:0] a, logic [31:0] d);
		bus(1'b1, a, d);
		case (a)
			32'h148: rng = d & 32'hFFFF;
			32'h14C: src = d & 32'h7FFC;
			32'h150: en = d & 32'h7FF8;
			32'h180: st = st & ~d;
			32'h184: msk = d & 32'h7FFC;
		endcase
	endtask
	task rdchk(string what, logic [31:0] a, int e);
		bus(1'b0, a, 32'h0);
		chk(what, e, rd);
	endtask
	task outs();
		logic [17:0] r;
		// Channel c takes range bit 15-c; the pairs follow channels 0 and 2.
		for (int c = 0; c < 16; c++) begin
			r[2 + c] = rng[15 - c];
		end
		r[1] = rng[15];
		r[0] = rng[13];
		expClr = ((src & st & 32'h7FF8) != 0) ? (en >> 3) & 32'hFFF : 0;
		if ((src & st & 32'h4) != 0) begin
			expClr = 32'hFFF;
		end
		repeat (3) @(posedge core_clk);
		chk("range select", r, rangeSel);
		chk("dac clear", expClr, dacForceClear);
		chk("irq", (st & msk) != 0, irq);
	endtask
	task results();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		void'($urandom(28));
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		outs();
		rdchk("range", 32'h148, rng);
		rdchk("source", 32'h14C, src);
		rdchk("enable", 32'h150, en);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			wr(32'h148, (i == 0) ? 32'h0 : $urandom);
			outs();
			rdchk("range", 32'h148, rng);
		end
		wr(32'h14C, 32'hFFFF);
		rdchk("source", 32'h14C, src);
		rdchk("unmapped", 32'h15C, 0);
		$display("test range done");
		for (int s = 0; s < 13; s++) begin
			for (int k = 0; k < 2; k++) begin
				wr(32'h180, 32'h7FFC);
				wr(32'h14C, k << (14 - s));
				wr(32'h150, $urandom);
				wr(32'h184, $urandom);
				@(posedge core_clk);
				alarmEvent <= 13'h1 << (12 - s);
				@(posedge core_clk);
				alarmEvent <= '0;
				st = st | (1 << (14 - s));
				outs();
				rdchk("status", 32'h180, st);
				rdchk("clear readback", 32'h188, expClr);
				rdchk("mask", 32'h184, msk);
				rdchk("enable", 32'h150, en);
			end
		end
		// An event standing through a status clear keeps its flag set.
		alarmEvent <= 13'h1000;
		wr(32'h180, 32'h7FFC);
		alarmEvent <= '0;
		st = st | 32'h4000;
		outs();
		rdchk("status kept", 32'h180, st);
		wr(32'h180, 32'h7FFC);
		outs();
		$display("test sources done");
		results();
	end
endmodule
